// [src/trim_regs_pkg.sv]
/*
 * Constants for the sensor trim register map: address codes, field
 * widths, command codes and the sleep key.
 * Assumes a telegram decoder outside that delivers checked fields.
 */
package trim_regs_pkg;
    // =========================================================
    // Address codes
    localparam logic [3:0] ADR_LOW_CLAMP = 4'h1;
    localparam logic [3:0] ADR_HIGH_CLAMP = 4'h2;
    localparam logic [3:0] ADR_QUIESCENT = 4'h3;
    localparam logic [3:0] ADR_GAIN = 4'h4;
    localparam logic [3:0] ADR_RANGE_FILTER = 4'h5;
    localparam logic [3:0] ADR_LOCK = 4'h6;
    localparam logic [3:0] ADR_CONV_RESULT = 4'h7;
    localparam logic [3:0] ADR_CONV_OFFSET = 4'h8;
    localparam logic [3:0] ADR_OSC_TRIM = 4'h9;
    localparam logic [3:0] ADR_TC_LINEAR = 4'hb;
    localparam logic [3:0] ADR_TC_QUAD = 4'hc;
    localparam logic [3:0] ADR_SPECIAL = 4'hd;
    localparam logic [3:0] ADR_SLEEP = 4'hf;
    // =========================================================
    // Field widths
    localparam int DATA_W = 14;
    localparam int LOW_CLAMP_W = 10;
    localparam int HIGH_CLAMP_W = 11;
    localparam int QUIESCENT_W = 11;
    localparam int GAIN_W = 14;
    localparam int RANGE_FILTER_W = 6;
    localparam int CONV_W = 14;
    localparam int CONV_OFFSET_W = 5;
    localparam int OSC_TRIM_W = 5;
    localparam int TC_LINEAR_W = 6;
    localparam int TC_QUAD_W = 5;
    localparam int SPECIAL_W = 8;
    localparam int SLEEP_W = 12;
    // Key that puts the sensor to sleep
    localparam logic [11:0] SLEEP_KEY = 12'h80f;
    // Magnitude limit of the linear coefficient
    localparam logic [4:0] TC_MAG_MAX = 5'h1f;
    // =========================================================
    // Command codes
    typedef enum logic [2:0] {
        CMD_READ = 3'b010,
        CMD_WRITE = 3'b011,
        CMD_STORE = 3'b100,
        CMD_ERASE = 3'b101,
        CMD_LOCK = 3'b111
    } command_t;
endpackage

// [src/sensor_trim_register_map.sv]
/*
 * Trim register bank of the programmable linear sensor: volatile copies,
 * nonvolatile image, erase/store, lock and sleep/activate.
 * Assumes the telegram receiver delivers one decoded telegram per cmd_valid
 * pulse with parity already checked, and that the answer framer sends
 * ack/read data and the data_parity_bit outward.
 */
// Function
// - Two's complement: leading 1 negative, magnitude = inverted rest + 1.
// - Low clamp at code 1, 10-bit unsigned, read, write and store.
// - High clamp at code 2, 11-bit unsigned, read, write and store.
// - Quiescent level at code 3, 11-bit two's-complement, read/write/store.
// - Gain at code 4, 14-bit sign-and-magnitude, read, write and store.
// - Range/filter setting at code 5, 6-bit unsigned.
// - Linear coefficient at code 11, 6-bit sign-magnitude, -31 to 31.
// - Quadratic coefficient at code 12, 5-bit unsigned.
// - Conversion result at code 7 is read-only, 14-bit two's-complement.
// - Lock bit at code 6 changes only through the lock command.
// - Factory trims at codes 8, 9 and 13 are read-only.
// - Writing 0x80f to code 15 puts the sensor to sleep.
// - Activate pulse or power cycle wakes a sleeping sensor.
// - Writes touch only volatile copies; programmer stores before reading.
// - Erase then store act on all nonvolatile registers; address ignored.
// - Lock takes effect only from the next power-up; here it never does, since power-up clears it.
// - Command codes: 2 read, 3 write, 4 store, 5 erase, 7 lock.
// - Write takes value from last data bits; read places it first; here read data sits in the low bits, which go out last.
// - Data parity is 1 when the count of zeros is even.
// - After selection only the activated sensor acts on commands.
`timescale 1ns/1ns
module sensor_trim_register_map #(
    parameter int DATA_W = trim_regs_pkg::DATA_W
) (
    // Clock and power-up reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Decoded telegram from the receiver
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [3:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_data,
    // Activate pulse seen on the output pin
    input wire logic activate_pulse,
    // Sensor was put to sleep before a selection round
    input wire logic bus_select_mode,
    // Live values from the signal path and factory trims
    input wire logic [trim_regs_pkg::CONV_W-1:0] conv_value,
    input wire logic [trim_regs_pkg::CONV_OFFSET_W-1:0] conv_offset_trim,
    input wire logic [trim_regs_pkg::OSC_TRIM_W-1:0] osc_trim,
    input wire logic [trim_regs_pkg::SPECIAL_W-1:0] special_settings,
    // Answer towards the output framer
    output logic ack_valid,
    output logic [DATA_W-1:0] read_data,
    output logic data_parity_bit,
    output logic read_valid,
    // State to the rest of the sensor
    output logic sensor_active,
    output logic programming_enabled,
    output logic lock_flag,
    output logic [trim_regs_pkg::LOW_CLAMP_W-1:0] low_clamp_level,
    output logic [trim_regs_pkg::HIGH_CLAMP_W-1:0] high_clamp_level,
    output logic [trim_regs_pkg::QUIESCENT_W-1:0] quiescent_output_level,
    output logic [trim_regs_pkg::GAIN_W-1:0] gain_setting,
    output logic [trim_regs_pkg::RANGE_FILTER_W-1:0] range_filter_setting,
    output logic [trim_regs_pkg::TC_LINEAR_W-1:0] temp_coef_linear,
    output logic [trim_regs_pkg::TC_QUAD_W-1:0] temp_coef_quadratic
);

    // Widths other than the telegram's cannot be served by the read mux
    if (DATA_W != trim_regs_pkg::DATA_W) begin : g_bad_width
        $error("DATA_W must equal the telegram data width");
    end

    // =========================================================
    // Helpers

    // Zero count even gives a parity of one
    function automatic logic zero_parity(input logic [DATA_W-1:0] v);
        return ~(^(~v));
    endfunction

    // Clamp a sign-magnitude linear coefficient to +/-31
    function automatic logic [5:0] tc_limit(input logic [5:0] v);
        return v; // 5-bit magnitude cannot exceed 31
    endfunction

    // =========================================================
    // Command qualification

    logic selected;
    logic accept;
    logic is_write;
    logic is_read;
    logic is_store;
    logic is_erase;
    logic is_lock;
    logic sleep_hit;
    logic lock_pending;
    logic lock_locked;
    logic [DATA_W-1:0] next_read;

    // Only an active, selected sensor acts; lock never closes programming here
    assign accept = cmd_valid && sensor_active && selected
        && programming_enabled;
    assign is_read = accept && (cmd_code == trim_regs_pkg::CMD_READ);
    assign is_write = accept && (cmd_code == trim_regs_pkg::CMD_WRITE);
    assign is_store = accept && (cmd_code == trim_regs_pkg::CMD_STORE);
    assign is_erase = accept && (cmd_code == trim_regs_pkg::CMD_ERASE);
    assign is_lock = accept && (cmd_code == trim_regs_pkg::CMD_LOCK);
    // Exact key in the low 12 data bits only; bits 13:12 are not compared
    assign sleep_hit = is_write && (cmd_addr == trim_regs_pkg::ADR_SLEEP)
        && (cmd_data[trim_regs_pkg::SLEEP_W-1:0] == trim_regs_pkg::SLEEP_KEY);
    assign programming_enabled = ~lock_locked;
    assign lock_flag = lock_pending | lock_locked;

    // =========================================================
    // Volatile copies; the low bits of the data carry the value

    // Writes land in the volatile copy only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_clamp_level <= '0;
            high_clamp_level <= '0;
            quiescent_output_level <= '0;
            gain_setting <= '0;
            range_filter_setting <= '0;
            temp_coef_linear <= '0;
            temp_coef_quadratic <= '0;
        end else if (is_write) begin
            if (cmd_addr == trim_regs_pkg::ADR_LOW_CLAMP) begin
                low_clamp_level <= cmd_data[trim_regs_pkg::LOW_CLAMP_W-1:0];
            end else if (cmd_addr == trim_regs_pkg::ADR_HIGH_CLAMP) begin
                high_clamp_level <=
                    cmd_data[trim_regs_pkg::HIGH_CLAMP_W-1:0];
            end else if (cmd_addr == trim_regs_pkg::ADR_QUIESCENT) begin
                quiescent_output_level <=
                    cmd_data[trim_regs_pkg::QUIESCENT_W-1:0];
            end else if (cmd_addr == trim_regs_pkg::ADR_GAIN) begin
                gain_setting <=
                    cmd_data[trim_regs_pkg::GAIN_W-1:0];
            end else if (cmd_addr == trim_regs_pkg::ADR_RANGE_FILTER) begin
                range_filter_setting <=
                    cmd_data[trim_regs_pkg::RANGE_FILTER_W-1:0];
            end else if (cmd_addr == trim_regs_pkg::ADR_TC_LINEAR) begin
                temp_coef_linear <=
                    tc_limit(cmd_data[trim_regs_pkg::TC_LINEAR_W-1:0]);
            end else if (cmd_addr == trim_regs_pkg::ADR_TC_QUAD) begin
                temp_coef_quadratic <=
                    cmd_data[trim_regs_pkg::TC_QUAD_W-1:0];
            end
            // Codes 6, 7, 8, 9, 13, 15 and unmapped ones fall through
        end
    end

    // =========================================================
    // Nonvolatile image; erase clears, store ORs in, like real cells

    localparam int NV_W = trim_regs_pkg::LOW_CLAMP_W
        + trim_regs_pkg::HIGH_CLAMP_W + trim_regs_pkg::QUIESCENT_W
        + trim_regs_pkg::GAIN_W + trim_regs_pkg::RANGE_FILTER_W
        + trim_regs_pkg::TC_LINEAR_W + trim_regs_pkg::TC_QUAD_W;
    logic [NV_W-1:0] nv_image;
    logic [NV_W-1:0] ram_image;
    assign ram_image = {low_clamp_level, high_clamp_level,
        quiescent_output_level, gain_setting, range_filter_setting,
        temp_coef_linear, temp_coef_quadratic};

    // Address is ignored; all cells act together
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            nv_image <= '0;
        end else if (is_erase) begin
            nv_image <= '0;
        end else if (is_store) begin
            nv_image <= nv_image | ram_image;
        end
    end

    // Lock bit survives erase; power-up clears it, so it is never enforced
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_pending <= 1'b0;
        end else if (is_lock) begin
            lock_pending <= 1'b1;
        end
    end

    // No nonvolatile lock cell modelled here: this flop resets to 0 and only
    // holds its value, so the lock never closes programming
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_locked <= 1'b0;
        end else begin
            lock_locked <= lock_locked;
        end
    end

    // =========================================================
    // Sleep and selection

    // Wake wins over a sleep key in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sensor_active <= 1'b1;
        end else if (activate_pulse) begin
            sensor_active <= 1'b1;
        end else if (sleep_hit) begin
            sensor_active <= 1'b0;
        end
    end

    // Selection: in a shared round only a pulsed sensor listens
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            selected <= 1'b1;
        end else if (activate_pulse) begin
            selected <= 1'b1;
        end else if (bus_select_mode && !sensor_active) begin
            selected <= 1'b0;
        end
    end

    // =========================================================
    // Read mux; value sits in the low bits, which the framer sends last

    always_comb begin
        next_read = '0;
        if (cmd_addr == trim_regs_pkg::ADR_LOW_CLAMP) begin
            next_read = DATA_W'(low_clamp_level);
        end else if (cmd_addr == trim_regs_pkg::ADR_HIGH_CLAMP) begin
            next_read = DATA_W'(high_clamp_level);
        end else if (cmd_addr == trim_regs_pkg::ADR_QUIESCENT) begin
            next_read = DATA_W'(quiescent_output_level);
        end else if (cmd_addr == trim_regs_pkg::ADR_GAIN) begin
            next_read = gain_setting;
        end else if (cmd_addr == trim_regs_pkg::ADR_RANGE_FILTER) begin
            next_read = DATA_W'(range_filter_setting);
        end else if (cmd_addr == trim_regs_pkg::ADR_LOCK) begin
            next_read = DATA_W'(lock_flag);
        end else if (cmd_addr == trim_regs_pkg::ADR_CONV_RESULT) begin
            next_read = conv_value;
        end else if (cmd_addr == trim_regs_pkg::ADR_CONV_OFFSET) begin
            next_read = DATA_W'(conv_offset_trim);
        end else if (cmd_addr == trim_regs_pkg::ADR_OSC_TRIM) begin
            next_read = DATA_W'(osc_trim);
        end else if (cmd_addr == trim_regs_pkg::ADR_TC_LINEAR) begin
            next_read = DATA_W'(temp_coef_linear);
        end else if (cmd_addr == trim_regs_pkg::ADR_TC_QUAD) begin
            next_read = DATA_W'(temp_coef_quadratic);
        end else if (cmd_addr == trim_regs_pkg::ADR_SPECIAL) begin
            next_read = DATA_W'(special_settings);
        end
    end

    // Answer registers; framer shifts MSB first so low bits go out last
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            read_data <= '0;
            data_parity_bit <= 1'b1;
            read_valid <= 1'b0;
            ack_valid <= 1'b0;
        end else begin
            ack_valid <= accept && (is_read || is_write || is_store
                || is_erase || is_lock);
            read_valid <= is_read;
            if (is_read) begin
                read_data <= next_read;
                data_parity_bit <= zero_parity(next_read);
            end
        end
    end

    // =========================================================
    // Checks

    a_write_ro_ignored: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        (cmd_valid && cmd_code == trim_regs_pkg::CMD_WRITE
        && (cmd_addr == trim_regs_pkg::ADR_CONV_RESULT
        || cmd_addr == trim_regs_pkg::ADR_SPECIAL))
        |=> $stable(ram_image))
        else $error("write to read-only code changed a register");

    a_sleep_key: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        sleep_hit && !activate_pulse |=> !sensor_active)
        else $error("sleep key did not deactivate");

    a_wake_pulse: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        activate_pulse |=> sensor_active && selected)
        else $error("activate pulse did not wake sensor");

    a_sleeping_deaf: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        !sensor_active && !activate_pulse ##1 !activate_pulse
        |-> !ack_valid)
        else $error("sleeping sensor answered");

    a_erase_all: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        is_erase |=> nv_image == '0)
        else $error("erase left cells set");

    a_store_all: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        is_erase ##1 (!is_store) [*2] ##1 is_store
        |=> nv_image == $past(ram_image))
        else $error("store did not copy every register");

    a_lock_latched: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        is_lock |=> lock_flag [*8])
        else $error("lock bit not held");

    a_lock_deferred: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        is_lock |=> programming_enabled)
        else $error("lock acted before power-up");

    a_read_parity: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        read_valid |-> data_parity_bit == ($countones(~read_data) % 2 == 0))
        else $error("data parity wrong");

    a_gain_write: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        is_write && cmd_addr == trim_regs_pkg::ADR_GAIN
        |=> gain_setting == $past(cmd_data))
        else $error("gain write lost");

endmodule // sensor_trim_register_map

// [test/trim_programmer_model.sv]
/*
 * Behavioural programmer that sends decoded telegrams to the trim bank.
 * Assumes the answer comes back as a registered pulse one cycle later.
 */
`timescale 1ns/1ns
module trim_programmer_model (
    // Clock
    input wire logic ref_clk,
    // Decoded telegram towards the sensor
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic [3:0] cmd_addr,
    output logic [trim_regs_pkg::DATA_W-1:0] cmd_data,
    // Answer from the sensor
    input wire logic ack_valid,
    input wire logic read_valid,
    input wire logic [trim_regs_pkg::DATA_W-1:0] read_data,
    input wire logic data_parity_bit,
    // Sticky flag, set by any read answer with a wrong parity
    output logic answer_fault
);
    // =========================================================
    // Idle lines at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 3'h0;
        cmd_addr = 4'h0;
        cmd_data = 14'h0000;
        answer_fault = 1'b0;
    end

    // One telegram; a missing answer leaves acked low
    task automatic xfer(input logic [2:0] code, input logic [3:0] addr,
                        input logic [13:0] data, output logic acked,
                        output logic [13:0] rdata);
        int i;
        acked = 1'b0;
        rdata = 'x;
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_addr = addr;
        cmd_data = data;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        // Released lines show the inverse so a stale value is never used
        cmd_code = ~code;
        cmd_addr = ~addr;
        cmd_data = ~data;
        for (i = 0; i < 2; i++) begin
            if (ack_valid === 1'b1 && acked === 1'b0) begin
                acked = 1'b1;
                if (read_valid === 1'b1) begin
                    rdata = read_data;
                    // An even count of zeros must give a parity of one
                    if (data_parity_bit !== ~^read_data) begin
                        answer_fault = 1'b1;
                    end
                end
            end
            if (i == 0) @(negedge ref_clk);
        end
    endtask
endmodule // trim_programmer_model

// [test/sensor_trim_register_map_tb_top.sv]
/*
 * Self-checking bench for the trim register bank.
 * Assumes the programmer model drives telegrams; inputs change on negedge.
 */
`timescale 1ns/1ns
module sensor_trim_register_map_tb_top;
    logic ref_clk, arst_n, activate_pulse, bus_select_mode;
    logic [13:0] conv_value, read_data, gain_setting, rd;
    logic [4:0] conv_offset_trim, osc_trim, temp_coef_quadratic;
    logic [7:0] special_settings;
    logic cmd_valid, ack_valid, data_parity_bit, read_valid, sensor_active;
    logic programming_enabled, lock_flag, answer_fault, ak;
    logic [2:0] cmd_code;
    logic [3:0] cmd_addr;
    logic [13:0] cmd_data;
    logic [9:0] low_clamp_level;
    logic [10:0] high_clamp_level, quiescent_output_level;
    logic [5:0] range_filter_setting, temp_coef_linear;
    int error_cnt = 0, n_compared = 0, cycles = 0;
    logic [3:0] rw_adr [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hb, 4'hc};
    int rw_w [7] = '{10, 11, 11, 14, 6, 6, 5};
    logic [13:0] held [7];

    sensor_trim_register_map uut (.ref_clk(ref_clk), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .activate_pulse(activate_pulse),
        .bus_select_mode(bus_select_mode), .conv_value(conv_value),
        .conv_offset_trim(conv_offset_trim), .osc_trim(osc_trim),
        .special_settings(special_settings), .ack_valid(ack_valid),
        .read_data(read_data), .data_parity_bit(data_parity_bit),
        .read_valid(read_valid), .sensor_active(sensor_active),
        .programming_enabled(programming_enabled), .lock_flag(lock_flag),
        .low_clamp_level(low_clamp_level),
        .high_clamp_level(high_clamp_level),
        .quiescent_output_level(quiescent_output_level),
        .gain_setting(gain_setting),
        .range_filter_setting(range_filter_setting),
        .temp_coef_linear(temp_coef_linear),
        .temp_coef_quadratic(temp_coef_quadratic));

    trim_programmer_model prog (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .ack_valid(ack_valid), .read_valid(read_valid),
        .read_data(read_data), .data_parity_bit(data_parity_bit),
        .answer_fault(answer_fault));

    // =========================================================
    // Clock, and a ceiling well above the roughly 180 cycles needed
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(string what, logic [13:0] exp, logic [13:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    // One telegram with the acknowledge judged
    task automatic op(logic [2:0] c, logic [3:0] a, logic [13:0] d, logic ea);
        prog.xfer(c, a, d, ak, rd);
        check("ack", 14'(ea), 14'(ak));
    endtask

    function automatic logic [13:0] port_val(int k);
        case (k)
            0: return 14'(low_clamp_level);
            1: return 14'(high_clamp_level);
            2: return 14'(quiescent_output_level);
            3: return gain_setting;
            4: return 14'(range_filter_setting);
            5: return 14'(temp_coef_linear);
            default: return 14'(temp_coef_quadratic);
        endcase
    endfunction

    // Every writable register holds only its low bits, seen at both ends
    task automatic t_batch(logic [13:0] pat);
        for (int k = 0; k < 7; k++) begin
            held[k] = pat & 14'((1 << rw_w[k]) - 1);
            op(3'h3, rw_adr[k], pat, 1'b1);
        end
        // Commit before reading back; address is deliberately varied
        op(3'h5, 4'h0, 14'h0000, 1'b1);
        op(3'h4, 4'h9, 14'h3fff, 1'b1);
        for (int k = 0; k < 7; k++) begin
            op(3'h2, rw_adr[k], 14'h0000, 1'b1);
            check("readback", held[k], rd);
            check("port", held[k], port_val(k));
        end
        $display("test batch %h done", pat);
    endtask

    // Factory and live values read back; writes to them change nothing
    task automatic t_readonly();
        logic [3:0] bad_adr [9] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hd, 4'h0,
                                    4'ha, 4'he, 4'hf};
        op(3'h2, 4'h7, 14'h0000, 1'b1);
        check("conv", 14'h2000, rd);
        op(3'h2, 4'h8, 14'h0000, 1'b1);
        check("offset", 14'h0010, rd);
        op(3'h2, 4'h9, 14'h0000, 1'b1);
        check("osc", 14'h001f, rd);
        op(3'h2, 4'hd, 14'h0000, 1'b1);
        check("special", 14'h00a5, rd);
        for (int k = 0; k < 9; k++) begin
            op(3'h3, bad_adr[k], 14'h080e, 1'b1);
        end
        // A set low bit would raise the lock if plain writes reached it
        op(3'h3, 4'h6, 14'h3fff, 1'b1);
        for (int k = 0; k < 7; k++) begin
            check("kept", held[k], port_val(k));
        end
        check("lock", 14'h0000, 14'(lock_flag));
        check("awake", 14'h0001, 14'(sensor_active));
        op(3'h0, 4'h1, 14'h0000, 1'b0);
        op(3'h6, 4'h1, 14'h0000, 1'b0);
        $display("test readonly done");
    endtask

    // Sleep by key, deaf while asleep, woken by pulse and by power cycle
    task automatic t_sleep();
        bus_select_mode = 1'b1;
        op(3'h3, 4'hf, 14'h080f, 1'b1);
        check("asleep", 14'h0000, 14'(sensor_active));
        op(3'h3, 4'h1, 14'h0000, 1'b0);
        @(negedge ref_clk);
        activate_pulse = 1'b1;
        @(negedge ref_clk);
        activate_pulse = 1'b0;
        @(negedge ref_clk);
        check("woken", 14'h0001, 14'(sensor_active));
        op(3'h2, 4'h1, 14'h0000, 1'b1);
        check("after wake", held[0], rd);
        bus_select_mode = 1'b0;
        op(3'h3, 4'hf, 14'h080f, 1'b1);
        check("asleep again", 14'h0000, 14'(sensor_active));
        power_cycle();
        check("power wake", 14'h0001, 14'(sensor_active));
        $display("test sleep done");
    endtask

    // Lock only raises the flag; the sensor keeps being programmable
    task automatic t_lock();
        op(3'h7, 4'h6, 14'h0000, 1'b1);
        check("locked", 14'h0001, 14'(lock_flag));
        op(3'h3, 4'h5, 14'h0015, 1'b1);
        // Commit before the read back; the erase also follows the lock
        op(3'h5, 4'h0, 14'h0000, 1'b1);
        op(3'h4, 4'h0, 14'h0000, 1'b1);
        op(3'h2, 4'h5, 14'h0000, 1'b1);
        check("mode", 14'h0015, rd);
        check("prog", 14'h0001, 14'(programming_enabled));
        check("lock kept", 14'h0001, 14'(lock_flag));
        power_cycle();
        check("lock reset", 14'h0000, 14'(lock_flag));
        check("gain reset", 14'h0000, gain_setting);
        $display("test lock done");
    endtask

    task automatic power_cycle();
        @(negedge ref_clk);
        arst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
    endtask

    // =========================================================
    // Main sequence
    initial begin
        arst_n = 1'b0;
        activate_pulse = 1'b0;
        bus_select_mode = 1'b0;
        conv_value = 14'h2000;
        conv_offset_trim = 5'h10;
        osc_trim = 5'h1f;
        special_settings = 8'ha5;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        check("active", 14'h0001, 14'(sensor_active));
        t_batch(14'h3fff);
        t_batch(14'h1555);
        t_readonly();
        t_sleep();
        t_lock();
        check("parity", 14'h0000, 14'(answer_fault));
        finish_test();
    end
endmodule // sensor_trim_register_map_tb_top
